// ### charger_control_four.sv
// Charger control four register with its detection-request sequencer.
// Assumes a byte register port from the serial front end, plus a converter and ADC
// that answer halt and sample handshakes on the same clock.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1: Bit 7 drives gate driver two; resets 0; locked 0 if pair absent.
// R2: Bit 6 drives gate driver one; resets 0; locked 0 if pair absent.
// R3: Bit 5 selects switching rate; power-on value comes from strap pin.
// R4: Bit 4 disables indicator pin; reset by power-on, register reset, watchdog.
// R5: Bit 3 disables rail short hiccup; reset by power-on, register reset only.
// R6: Bit 2 disables boost undervoltage hiccup; reset by power-on, register reset.
// R7: Bit 1 takes a write of 1 only when battery exceeds minimum system voltage.
// R8: Request halts switching, samples input with no current, loads limit register.
// R9: Request bit clears itself after detection completes; reset otherwise to 0.
// R10: Bit 0 enables input overcurrent guard; defaults 1; power-on, register reset.
// R11: Master gate driver disable forces both gate driver bits to 0.
// R12: One write updates all bits; read-back shows enforced effective values.
module charger_control_four (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reg_reset,
  input wire logic watchdog_expired,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic config_strap_pin,
  input wire logic path_one_present,
  input wire logic path_two_present,
  input wire logic gate_drivers_master_off,
  input wire logic battery_above_minimum,
  input wire logic adc_sample_done,
  input wire logic [7:0] adc_input_supply_voltage,
  output logic gate_driver_two_on,
  output logic gate_driver_one_on,
  output logic switching_rate_select,
  output logic indicator_pin_off,
  output logic rail_short_hiccup_off,
  output logic boost_undervolt_hiccup_off,
  output logic input_limit_detect_request,
  output logic input_overcurrent_guard_on,
  output logic converter_halt,
  output logic adc_sample_start,
  output logic input_voltage_limit_load,
  output logic [7:0] input_voltage_limit
);
  logic strap_sync;
  logic [1:0] present_sync;
  logic boot_done;
  logic [1:0] boot_wait, next_boot_wait;
  logic path_one_ok, path_two_ok;
  logic next_path_one_ok, next_path_two_ok, next_boot_done;
  logic next_gd_two, next_gd_one, next_rate, next_ind, next_rail, next_boost;
  logic next_req, next_ocp;
  logic [7:0] next_limit;
  charger_control_four_pkg::detect_state_e det_state, next_det_state;
  logic wr_hit;

  // Pins from outside the clock domain
  sync_two_flop #(.width(3)) pin_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in({config_strap_pin, path_two_present, path_one_present}),
    .sync_out({strap_sync, present_sync})
  );

  assign wr_hit = reg_write && (reg_addr == charger_control_four_pkg::charger_control_four_offset);

  // Next register values; power-on capture, resets, writes and the sequencer
  always_comb begin
    // Capture stays open until the synchroniser shows the pins, not its reset zeros
    next_boot_wait = (boot_wait == charger_control_four_pkg::strap_settle_count) ? boot_wait
                     : boot_wait + 2'd1;
    next_boot_done = (boot_wait == charger_control_four_pkg::strap_settle_count);
    next_path_one_ok = path_one_ok;
    next_path_two_ok = path_two_ok;
    next_gd_two = gate_driver_two_on;
    next_gd_one = gate_driver_one_on;
    next_rate = switching_rate_select;
    next_ind = indicator_pin_off;
    next_rail = rail_short_hiccup_off;
    next_boost = boost_undervolt_hiccup_off;
    next_req = input_limit_detect_request;
    next_ocp = input_overcurrent_guard_on;
    next_limit = input_voltage_limit;
    next_det_state = det_state;
    if (!boot_done) begin
      // Straps are re-caught each edge; the last catch sees settled pin levels
      next_rate = strap_sync; // R3
      next_path_one_ok = present_sync[0]; // R2
      next_path_two_ok = present_sync[1]; // R1
    end else if (reg_reset) begin
      // Gate driver bits are cleared and the rate bit strapped by power-on only, so kept here
      next_ind = charger_control_four_pkg::indicator_pin_off_rst; // R4
      next_rail = charger_control_four_pkg::rail_short_hiccup_off_rst; // R5
      next_boost = charger_control_four_pkg::boost_undervolt_hiccup_off_rst; // R6
      next_req = charger_control_four_pkg::input_limit_detect_request_rst; // R9
      next_ocp = charger_control_four_pkg::input_overcurrent_guard_on_rst; // R10
      next_det_state = charger_control_four_pkg::det_idle;
    end else begin
      if (wr_hit) begin
        // Whole byte taken in one access
        next_gd_two = reg_wdata[charger_control_four_pkg::gate_driver_two_on_bit]; // R12
        next_gd_one = reg_wdata[charger_control_four_pkg::gate_driver_one_on_bit];
        next_rate = reg_wdata[charger_control_four_pkg::switching_rate_select_bit];
        next_ind = reg_wdata[charger_control_four_pkg::indicator_pin_off_bit];
        next_rail = reg_wdata[charger_control_four_pkg::rail_short_hiccup_off_bit];
        next_boost = reg_wdata[charger_control_four_pkg::boost_undervolt_hiccup_off_bit];
        next_ocp = reg_wdata[charger_control_four_pkg::input_overcurrent_guard_on_bit];
        // Writing 0 cannot abort a running detection; only a gated 1 starts one
        if (reg_wdata[charger_control_four_pkg::input_limit_detect_request_bit]
            && battery_above_minimum) begin
          next_req = 1'b1; // R7
        end
      end
      // Watchdog expiry is a reset, so it beats a write in the same cycle
      if (watchdog_expired) begin
        next_ind = charger_control_four_pkg::indicator_pin_off_rst; // R4
      end
      // Detection sequencer
      case (det_state)
        charger_control_four_pkg::det_idle: begin
          if (input_limit_detect_request) begin
            next_det_state = charger_control_four_pkg::det_halt; // R8
          end
        end
        charger_control_four_pkg::det_halt: begin
          next_det_state = charger_control_four_pkg::det_sample;
        end
        charger_control_four_pkg::det_sample: begin
          if (adc_sample_done) begin
            next_limit = adc_input_supply_voltage; // R8
            next_det_state = charger_control_four_pkg::det_load;
          end
        end
        charger_control_four_pkg::det_load: begin
          next_req = 1'b0; // R9
          next_det_state = charger_control_four_pkg::det_idle;
        end
        default: next_det_state = charger_control_four_pkg::det_idle;
      endcase
    end
    // Locks applied last so read-back shows the enforced value
    if (!next_path_two_ok || gate_drivers_master_off) begin
      next_gd_two = 1'b0; // R1 R11
    end
    if (!next_path_one_ok || gate_drivers_master_off) begin
      next_gd_one = 1'b0; // R2 R11
    end
  end

  // Register stage only
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      boot_done <= 1'b0;
      boot_wait <= 2'd0;
      path_one_ok <= 1'b0;
      path_two_ok <= 1'b0;
      gate_driver_two_on <= charger_control_four_pkg::gate_driver_two_on_rst;
      gate_driver_one_on <= charger_control_four_pkg::gate_driver_one_on_rst;
      switching_rate_select <= 1'b0;
      indicator_pin_off <= charger_control_four_pkg::indicator_pin_off_rst;
      rail_short_hiccup_off <= charger_control_four_pkg::rail_short_hiccup_off_rst;
      boost_undervolt_hiccup_off <= charger_control_four_pkg::boost_undervolt_hiccup_off_rst;
      input_limit_detect_request <= charger_control_four_pkg::input_limit_detect_request_rst;
      input_overcurrent_guard_on <= charger_control_four_pkg::input_overcurrent_guard_on_rst;
      input_voltage_limit <= 8'h00;
      det_state <= charger_control_four_pkg::det_idle;
    end else begin
      boot_done <= next_boot_done;
      boot_wait <= next_boot_wait;
      path_one_ok <= next_path_one_ok;
      path_two_ok <= next_path_two_ok;
      gate_driver_two_on <= next_gd_two;
      gate_driver_one_on <= next_gd_one;
      switching_rate_select <= next_rate;
      indicator_pin_off <= next_ind;
      rail_short_hiccup_off <= next_rail;
      boost_undervolt_hiccup_off <= next_boost;
      input_limit_detect_request <= next_req;
      input_overcurrent_guard_on <= next_ocp;
      input_voltage_limit <= next_limit;
      det_state <= next_det_state;
    end
  end

  // Sequencer handshakes
  assign converter_halt = (det_state != charger_control_four_pkg::det_idle); // R8
  assign adc_sample_start = (det_state == charger_control_four_pkg::det_sample);
  assign input_voltage_limit_load = (det_state == charger_control_four_pkg::det_load);

  // Read-back of the effective byte
  always_comb begin
    if (reg_addr == charger_control_four_pkg::charger_control_four_offset) begin
      reg_rdata = {gate_driver_two_on, gate_driver_one_on, switching_rate_select,
                   indicator_pin_off, rail_short_hiccup_off, boost_undervolt_hiccup_off,
                   input_limit_detect_request, input_overcurrent_guard_on}; // R12
    end else begin
      reg_rdata = 8'h00;
    end
  end

  lock_two_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    boot_done && !path_two_ok |-> !gate_driver_two_on) else $error("gate two not locked"); // R1
  lock_one_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    boot_done && !path_one_ok |-> !gate_driver_one_on) else $error("gate one not locked"); // R2
  strap_rate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !boot_done |=> switching_rate_select == $past(strap_sync)) else $error("strap lost"); // R3
  watchdog_ind_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    boot_done && watchdog_expired && !reg_reset |=> !indicator_pin_off)
    else $error("watchdog did not clear indicator"); // R4
  watchdog_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    boot_done && watchdog_expired && !reg_reset && !wr_hit |=> $stable(rail_short_hiccup_off)
    && $stable(boost_undervolt_hiccup_off)) else $error("watchdog touched hiccup bits"); // R5
  reg_reset_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    boot_done && reg_reset |=> !boost_undervolt_hiccup_off && input_overcurrent_guard_on
    && !input_limit_detect_request) else $error("register reset values wrong"); // R6
  request_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !input_limit_detect_request ##1 input_limit_detect_request |->
    $past(battery_above_minimum) && $past(wr_hit)) else $error("request taken ungated"); // R7
  halt_then_sample_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    input_limit_detect_request && det_state == charger_control_four_pkg::det_idle && !reg_reset
    |=> converter_halt ##1 adc_sample_start) else $error("detection did not start"); // R8
  self_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    input_voltage_limit_load && !reg_reset |=> !input_limit_detect_request)
    else $error("request did not clear"); // R9
  reset_keeps_gates_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    boot_done && reg_reset && !gate_drivers_master_off |=>
    gate_driver_two_on == $past(gate_driver_two_on)
    && gate_driver_one_on == $past(gate_driver_one_on))
    else $error("register reset touched gate bits"); // R1
  master_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    gate_drivers_master_off |=> !gate_driver_one_on && !gate_driver_two_on)
    else $error("master disable ignored"); // R11
endmodule : charger_control_four
`default_nettype wire

// ### charger_control_four_pkg.sv
// Package for the charger control four register block.
// Assumes a byte-wide register access port from the two-wire serial front end.
`default_nettype none
package charger_control_four_pkg;
  localparam logic [7:0] charger_control_four_offset = 8'h13;
  // Edges the pin synchroniser needs before it shows the real strap levels
  localparam logic [1:0] strap_settle_count = 2'd2;
  // Field positions
  localparam int gate_driver_two_on_bit = 7;
  localparam int gate_driver_one_on_bit = 6;
  localparam int switching_rate_select_bit = 5;
  localparam int indicator_pin_off_bit = 4;
  localparam int rail_short_hiccup_off_bit = 3;
  localparam int boost_undervolt_hiccup_off_bit = 2;
  localparam int input_limit_detect_request_bit = 1;
  localparam int input_overcurrent_guard_on_bit = 0;
  // Reset values, strap bit excluded
  localparam logic gate_driver_two_on_rst = 1'b0;
  localparam logic gate_driver_one_on_rst = 1'b0;
  localparam logic indicator_pin_off_rst = 1'b0;
  localparam logic rail_short_hiccup_off_rst = 1'b0;
  localparam logic boost_undervolt_hiccup_off_rst = 1'b0;
  localparam logic input_limit_detect_request_rst = 1'b0;
  localparam logic input_overcurrent_guard_on_rst = 1'b1;
  // Detection sequencer states
  typedef enum logic [1:0] {det_idle, det_halt, det_sample, det_load} detect_state_e;
endpackage : charger_control_four_pkg
`default_nettype wire

// ### sync_two_flop.sv
// Two-flop synchroniser for asynchronous level inputs.
// Assumes inputs are slow levels; no pulse is guaranteed to pass.
`timescale 1ns/100ps
`default_nettype none
module sync_two_flop #(
  parameter int width = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage_one;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule : sync_two_flop
`default_nettype wire

// ### adc_sample_model.sv
// Behavioural model of the converter's ADC answering the detection sequencer.
// Assumes start is a level on the same clock and is dropped after done is seen.
`timescale 1ns/100ps
`default_nettype none
module adc_sample_model #(
  parameter int delay = 4
) (
  input wire logic sys_clk,
  input wire logic start,
  input wire logic [7:0] measured,
  output logic done,
  output logic [7:0] result
);
  int cnt = 0;
  // One done pulse per request; the result toggles when not valid, so stale data matches only every other cycle
  always @(posedge sys_clk) begin
    if (start && !done && cnt == delay) begin
      done <= 1'b1;
      result <= measured;
      cnt <= 0;
    end else begin
      done <= 1'b0;
      result <= ~result;
      cnt <= (start && !done) ? cnt + 1 : 0;
    end
  end
  initial begin
    done = 1'b0;
    result = 8'h00;
  end
endmodule : adc_sample_model
`default_nettype wire

// ### test_charger_control_four.sv
// Self-checking bench for the charger control four register.
// Assumes a combinational read port and writes taken on the rising edge.
`timescale 1ns/100ps
`default_nettype none
module test_charger_control_four;
  logic sys_clk = 1'b0, rstn = 1'b0, reg_reset = 1'b0, watchdog_expired = 1'b0;
  logic reg_write = 1'b0, config_strap_pin = 1'b1, path_one_present = 1'b1;
  logic path_two_present = 1'b1, gate_drivers_master_off = 1'b0, battery_above_minimum = 1'b0;
  logic [7:0] reg_addr = 8'h13, reg_wdata = 8'h00, reg_rdata, input_voltage_limit;
  logic adc_sample_done, converter_halt, adc_sample_start, input_voltage_limit_load;
  logic [7:0] adc_input_supply_voltage;
  // Each bit has its own port driver, so this is a net
  wire logic [7:0] outs;
  logic halt_seen, load_seen;
  int error_cnt = 0, tests_run = 0;
  always #10 sys_clk = ~sys_clk;
  charger_control_four charger_control_four_i (.sys_clk(sys_clk), .rstn(rstn),
    .reg_reset(reg_reset), .watchdog_expired(watchdog_expired), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .config_strap_pin(config_strap_pin), .path_one_present(path_one_present),
    .path_two_present(path_two_present), .gate_drivers_master_off(gate_drivers_master_off),
    .battery_above_minimum(battery_above_minimum), .adc_sample_done(adc_sample_done),
    .adc_input_supply_voltage(adc_input_supply_voltage),
    .gate_driver_two_on(outs[7]), .gate_driver_one_on(outs[6]),
    .switching_rate_select(outs[5]), .indicator_pin_off(outs[4]),
    .rail_short_hiccup_off(outs[3]), .boost_undervolt_hiccup_off(outs[2]),
    .input_limit_detect_request(outs[1]), .input_overcurrent_guard_on(outs[0]),
    .converter_halt(converter_halt), .adc_sample_start(adc_sample_start),
    .input_voltage_limit_load(input_voltage_limit_load),
    .input_voltage_limit(input_voltage_limit));
  adc_sample_model adc_sample_model_i (.sys_clk(sys_clk), .start(adc_sample_start),
    .measured(8'h5a), .done(adc_sample_done), .result(adc_input_supply_voltage));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  // Read is combinational, so compare a little after the address settles
  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = addr;
    #1 chk(reg_rdata, exp);
    if (addr == 8'h13) chk(outs, exp);
  endtask : rdchk
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk);
    reg_write = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge sys_clk);
    reg_write = 1'b0;
    reg_addr = 8'h13;
  endtask : wr
  // Straps must stay put through the synchroniser, hence the extra edges after release
  task automatic power_on(input logic strap, input logic p1, input logic p2);
    @(negedge sys_clk);
    rstn = 1'b0;
    config_strap_pin = strap;
    path_one_present = p1;
    path_two_present = p2;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask : power_on
  task automatic wrap_up;
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    power_on(1'b1, 1'b1, 1'b1);
    rdchk(8'h13, 8'h21);
    wr(8'h13, 8'hdc);
    rdchk(8'h13, 8'hdc);
    wr(8'h12, 8'h00);
    rdchk(8'h12, 8'h00);
    rdchk(8'h13, 8'hdc);
    @(negedge sys_clk) watchdog_expired = 1'b1;
    @(negedge sys_clk) watchdog_expired = 1'b0;
    rdchk(8'h13, 8'hcc);
    @(negedge sys_clk) gate_drivers_master_off = 1'b1;
    rdchk(8'h13, 8'h0c);
    wr(8'h13, 8'hcc);
    rdchk(8'h13, 8'h0c);
    @(negedge sys_clk) gate_drivers_master_off = 1'b0;
    // Battery low, so the detection request must be refused
    wr(8'h13, 8'hfe);
    rdchk(8'h13, 8'hfc);
    @(negedge sys_clk) reg_reset = 1'b1;
    @(negedge sys_clk) reg_reset = 1'b0;
    rdchk(8'h13, 8'he1);
    // Detection: bounded wait for the request to clear itself
    battery_above_minimum = 1'b1;
    wr(8'h13, 8'h03);
    halt_seen = converter_halt;
    load_seen = 1'b0;
    for (int i = 0; i < 40 && !(halt_seen && !outs[1]); i++) begin
      @(negedge sys_clk);
      halt_seen |= converter_halt;
      load_seen |= input_voltage_limit_load;
    end
    chk({6'h00, halt_seen, load_seen}, 8'h03);
    chk(input_voltage_limit, 8'h5a);
    rdchk(8'h13, 8'h01);
    chk({7'h00, converter_halt}, 8'h00);
    // Second power-on with pair two absent and the strap low
    power_on(1'b0, 1'b1, 1'b0);
    rdchk(8'h13, 8'h01);
    wr(8'h13, 8'hc1);
    rdchk(8'h13, 8'h41);
    power_on(1'b0, 1'b0, 1'b1);
    wr(8'h13, 8'hc1);
    rdchk(8'h13, 8'h81);
    wrap_up();
  end
  // The whole sequence needs about 120 cycles; this limit leaves wide margin
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end
endmodule : test_charger_control_four
`default_nettype wire
